// ===== verilog/sm_modulator.sv
// Operation
// - Disable stops mixing and holds output low, or high with output invert set, keeping source selections.
// - Re-enable resumes mixing with retained selections.
// - Modulator high passes carrier-high, low passes carrier-low, ANDed.
// - Six-bit source field: 0 pin, 1 software bit, higher peripherals; 0x0B, 0x0C and above 0x20 reserved.
// - Five-bit carrier-high select: 0 pin, 1 system clock, top codes reserved.
// - Five-bit carrier-low select with the same code arrangement.
// - High sync holds carrier-high until its falling edge before switching.
// - Low sync holds carrier-low until its falling edge before switching.
// - Without sync the carrier switches immediately on modulator change.
// - Carrier-high invert bit inverts selected carrier-high input.
// - Carrier-low invert bit inverts selected carrier-low input.
// - Output invert bit inverts modulated output, idling high.
// - Control status bit shows current modulated output level.
// - Software bit drives modulator only when source selects it.
// - Reset disables module and returns all registers to defaults.
// - Power disable shuts module down; registers at defaults afterward.
// - Keeps operating in sleep while its sources keep running.
// - Enable, status, output invert and software bit reset to zero.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "sm_regs.svh"
module sm_modulator #(
    parameter int MS_INPUTS  = 33, // Modulator source codes in use
    parameter int CAR_INPUTS = 23  // Carrier source codes in use
) (
    input  wire logic                  core_clk,            // 20 MHz clock
    input  wire logic                  reset_n,             // Sync reset, active low
    input  wire logic                  clk_en,              // Clock enable
    input  wire logic                  module_power_disable, // Power-down control
    input  wire logic [7:0]            reg_addr,            // Register address
    input  wire logic [7:0]            reg_wdata,           // Write data
    input  wire logic                  reg_wr,              // Write strobe
    input  wire logic                  reg_rd,              // Read strobe
    output var  logic [7:0]            reg_rdata,           // Read data, next cycle
    input  wire logic                  modulator_pin_route,    // Modulator pin input
    input  wire logic                  carrier_high_pin_route, // Carrier-high pin input
    input  wire logic                  carrier_low_pin_route,  // Carrier-low pin input
    input  wire logic [MS_INPUTS-1:0]  mod_periph_in,       // Modulator sources by code
    input  wire logic [CAR_INPUTS-1:0] carrier_high_signal_periph_in,      // Carrier-high sources by code
    input  wire logic [CAR_INPUTS-1:0] carrier_low_signal_periph_in,      // Carrier-low sources by code
    output var  logic                  modulated_output,    // Modulated output
    output var  logic                  carrier_active_high  // Carrier in use is high one
);
    localparam int NSYNC = MS_INPUTS + 2 * CAR_INPUTS + 3;

    logic [7:0]  control_q, carrier_options_q, mod_src_q, carrier_low_signal_sel_q, carrier_high_signal_sel_q;
    logic        out_q;
    logic        mod_prev_q;
    logic        carrier_high_signal_prev_q, carrier_low_signal_prev_q;
    sm_pkg::sm_car_e car_q, car_d;
    logic [NSYNC-1:0] raw_in, sync_in;

    // All outside sources cross into the clock domain first
    assign raw_in = {carrier_low_signal_periph_in, carrier_high_signal_periph_in, mod_periph_in,
                     carrier_low_pin_route, carrier_high_pin_route, modulator_pin_route};

    sm_sync2 #(.WIDTH(NSYNC)) u_sync (
        .core_clk (core_clk),
        .clk_en   (clk_en),
        .async_in (raw_in),
        .sync_out (sync_in)
    );

    wire                  mod_pin_s  = sync_in[0];
    wire                  carrier_high_signal_pin_s = sync_in[1];
    wire                  carrier_low_signal_pin_s = sync_in[2];
    wire [MS_INPUTS-1:0]  mod_per_s  = sync_in[3 +: MS_INPUTS];
    wire [CAR_INPUTS-1:0] carrier_high_signal_per_s = sync_in[3+MS_INPUTS +: CAR_INPUTS];
    wire [CAR_INPUTS-1:0] carrier_low_signal_per_s = sync_in[3+MS_INPUTS+CAR_INPUTS +: CAR_INPUTS];

    // Carrier selection shared by both carrier paths; reserved codes give low
    function automatic logic car_pick(input sm_pkg::sm_csel_t sel,
                                      input logic pin,
                                      input logic [CAR_INPUTS-1:0] per);
        logic v;
        v = 1'b0;
        if (sel == `SM_CAR_PIN)
            v = pin;
        else if (sel == `SM_CAR_RSVD || sel > `SM_CAR_LAST)
            v = 1'b0;
        else
            v = per[sel];
        return v;
    endfunction : car_pick

    // Register decode and field views
    wire hit_ctl  = reg_addr == `SM_OFF_CONTROL;
    wire hit_opt  = reg_addr == `SM_OFF_CARRIER_OPT;
    wire hit_src  = reg_addr == `SM_OFF_MOD_SRC;
    wire hit_carrier_low_signal = reg_addr == `SM_OFF_CARRIER_LOW_SIGNAL_SEL;
    wire hit_carrier_high_signal = reg_addr == `SM_OFF_CARRIER_HIGH_SIGNAL_SEL;

    wire enable_bit               = control_q[`SM_CTL_EN];
    wire output_invert            = control_q[`SM_CTL_OUTPUT_INVERT];
    wire software_modulation_bit  = control_q[`SM_CTL_BIT];
    wire carrier_high_invert      = carrier_options_q[`SM_OPT_CARRIER_HIGH_INVERT];
    wire carrier_high_sync_enable = carrier_options_q[`SM_OPT_CARRIER_HIGH_SYNC_ENABLE];
    wire carrier_low_invert       = carrier_options_q[`SM_OPT_CARRIER_LOW_INVERT];
    wire carrier_low_sync_enable  = carrier_options_q[`SM_OPT_CARRIER_LOW_SYNC_ENABLE];
    wire sm_pkg::sm_msel_t modulator_source_field = mod_src_q[5:0];
    wire sm_pkg::sm_csel_t carrier_high_field     = carrier_high_signal_sel_q[4:0];
    wire sm_pkg::sm_csel_t carrier_low_field      = carrier_low_signal_sel_q[4:0];

    // Modulator source mux
    wire ms_rsvd = modulator_source_field == `SM_MS_RSVD_A ||
                   modulator_source_field == `SM_MS_RSVD_B ||
                   modulator_source_field > `SM_MS_LAST;
    wire modulator_signal =
        (modulator_source_field == `SM_MS_PIN)   ? mod_pin_s :
        (modulator_source_field == `SM_MS_SWBIT) ? software_modulation_bit :
        ms_rsvd ? 1'b0 : mod_per_s[modulator_source_field];

    // Carrier muxes with polarity
    wire carrier_high_signal = car_pick(carrier_high_field, carrier_high_signal_pin_s, carrier_high_signal_per_s)
                               ^ carrier_high_invert;
    wire carrier_low_signal  = car_pick(carrier_low_field, carrier_low_signal_pin_s, carrier_low_signal_per_s)
                               ^ carrier_low_invert;

    // Carrier hand-over: wait for a falling edge when sync is on
    wire carrier_high_signal_fall = carrier_high_signal_prev_q & ~carrier_high_signal;
    wire carrier_low_signal_fall = carrier_low_signal_prev_q & ~carrier_low_signal;
    wire want_high = modulator_signal;
    wire hold_high = carrier_high_sync_enable & carrier_high_signal & ~carrier_high_signal_fall;
    wire hold_low  = carrier_low_sync_enable & carrier_low_signal & ~carrier_low_signal_fall;
    always_comb begin
        car_d = car_q;
        case (car_q)
            sm_pkg::SM_USE_HIGH: begin
                if (!want_high && !hold_high)
                    car_d = sm_pkg::SM_USE_LOW;
            end
            sm_pkg::SM_USE_LOW: begin
                if (want_high && !hold_low)
                    car_d = sm_pkg::SM_USE_HIGH;
            end
            default: car_d = sm_pkg::SM_USE_LOW;
        endcase
    end

    // Mixer: modulator ANDs the carrier high, its inverse ANDs the low
    wire car_is_high = car_d == sm_pkg::SM_USE_HIGH;
    wire mix_raw = car_is_high ? (carrier_high_signal & (modulator_signal | hold_high))
                               : (carrier_low_signal & (~modulator_signal | hold_low));
    wire mix_out = (enable_bit & mix_raw) ^ output_invert;

    // Held in reset while powered down so all registers return to defaults
    wire clear = !reset_n || module_power_disable;

    // Register writes
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (clear) begin
                control_q         <= `SM_RST_BYTE;
                carrier_options_q <= `SM_RST_BYTE;
                mod_src_q         <= `SM_RST_BYTE;
                carrier_low_signal_sel_q        <= `SM_RST_BYTE;
                carrier_high_signal_sel_q        <= `SM_RST_BYTE;
            end else if (reg_wr) begin
                if (hit_ctl)
                    control_q <= reg_wdata & 8'h91;   // Status bit is read-only
                if (hit_opt)
                    carrier_options_q <= reg_wdata & 8'h33;
                if (hit_src)
                    mod_src_q <= reg_wdata & 8'h3F;
                if (hit_carrier_low_signal)
                    carrier_low_signal_sel_q <= reg_wdata & 8'h1F;
                if (hit_carrier_high_signal)
                    carrier_high_signal_sel_q <= reg_wdata & 8'h1F;
            end
        end
    end

    // Mixer state; selections survive enable toggles
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (clear) begin
                car_q       <= sm_pkg::SM_USE_LOW;
                out_q       <= 1'b0;
                mod_prev_q  <= 1'b0;
                carrier_high_signal_prev_q <= 1'b0;
                carrier_low_signal_prev_q <= 1'b0;
            end else begin
                car_q       <= car_d;
                out_q       <= mix_out;
                mod_prev_q  <= modulator_signal;
                carrier_high_signal_prev_q <= carrier_high_signal;
                carrier_low_signal_prev_q <= carrier_low_signal;
            end
        end
    end

    // Read port: data in the cycle after the strobe
    wire [7:0] ctl_view = {control_q[7:6], out_q, control_q[4:0]};
    wire [7:0] rd_mux   = hit_ctl  ? ctl_view :
                          hit_opt  ? carrier_options_q :
                          hit_src  ? mod_src_q :
                          hit_carrier_low_signal ? carrier_low_signal_sel_q :
                          hit_carrier_high_signal ? carrier_high_signal_sel_q : 8'h00;
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (!reset_n)
                reg_rdata <= 8'h00;
            else
                reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Output pins
    assign modulated_output    = out_q;
    assign carrier_active_high = car_q == sm_pkg::SM_USE_HIGH;

    // Edge marker and plain mix, used only by the checks below
    wire mod_edge  = modulator_signal ^ mod_prev_q;
    wire plain_mix = modulator_signal ? carrier_high_signal : carrier_low_signal;

    // One flag per modulator code: true for wired peripheral slots
    logic [MS_INPUTS-1:0] ms_code_ok;
    for (genvar g = 0; g < MS_INPUTS; g++) begin : g_ms_ok
        assign ms_code_ok[g] = 6'(g) > `SM_MS_SWBIT && 6'(g) != `SM_MS_RSVD_A &&
                               6'(g) != `SM_MS_RSVD_B;
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n || !clk_en);

    disabled_out_low_a: assert property (
        !enable_bit && !output_invert && !module_power_disable |=> !modulated_output)
        else $error("output not low while disabled");
    output_invert_a: assert property (
        !enable_bit && output_invert && !module_power_disable && $stable(control_q)
        |=> modulated_output) else $error("inverted idle not high");
    status_mirror_a: assert property (
        reg_rd && hit_ctl && !module_power_disable |=> reg_rdata[5] == $past(out_q))
        else $error("status bit mismatch");
    power_clear_a: assert property (
        module_power_disable |=> control_q == 8'h00 && mod_src_q == 8'h00)
        else $error("registers not cleared on power down");
    sel_retained_a: assert property (
        reg_wr && hit_ctl && !module_power_disable |=> $stable(mod_src_q))
        else $error("selection lost on enable write");
    swbit_drive_a: assert property (
        enable_bit && modulator_source_field == `SM_MS_SWBIT && !module_power_disable
        |-> modulator_signal == software_modulation_bit) else $error("software bit ignored");
    high_sync_hold_a: assert property (
        car_q == sm_pkg::SM_USE_HIGH && hold_high |-> car_d == sm_pkg::SM_USE_HIGH)
        else $error("left high carrier before fall");
    nosync_switch_a: assert property (
        !carrier_high_sync_enable && !carrier_low_sync_enable
        |-> car_d == (modulator_signal ? sm_pkg::SM_USE_HIGH : sm_pkg::SM_USE_LOW))
        else $error("unsynchronised switch delayed");
    cv_enabled: cover property (enable_bit ##1 modulated_output);
    cv_switch: cover property (car_q == sm_pkg::SM_USE_HIGH ##1 car_q == sm_pkg::SM_USE_LOW);
    cv_hold: cover property (hold_low && modulator_signal);
    cv_sync_edge: cover property (mod_edge && hold_high);
    cv_power: cover property (module_power_disable ##1 !module_power_disable);

    // Source selection, reserved codes and polarity
    pin_source_a: assert property (
        modulator_source_field == `SM_MS_PIN |-> modulator_signal == mod_pin_s)
        else $error("pin source not selected");

    periph_source_a: assert property (
        modulator_source_field <= `SM_MS_LAST && ms_code_ok[modulator_source_field]
        |-> modulator_signal == mod_per_s[modulator_source_field])
        else $error("peripheral source not selected");

    rsvd_source_a: assert property (
        ms_rsvd |-> !modulator_signal) else $error("reserved source not low");

    rsvd_carrier_a: assert property (
        carrier_high_field > `SM_CAR_LAST |-> carrier_high_signal == carrier_high_invert)
        else $error("reserved carrier not low");

    carrier_high_signal_sysclk_a: assert property (
        carrier_high_field == `SM_CAR_SYSCLK
        |-> carrier_high_signal == (carrier_high_signal_per_s[`SM_CAR_SYSCLK] ^ carrier_high_invert))
        else $error("carrier-high clock source not selected");

    carrier_low_signal_sysclk_a: assert property (
        carrier_low_field == `SM_CAR_SYSCLK
        |-> carrier_low_signal == (carrier_low_signal_per_s[`SM_CAR_SYSCLK] ^ carrier_low_invert))
        else $error("carrier-low clock source not selected");

    carrier_high_signal_invert_a: assert property (
        carrier_high_field == `SM_CAR_PIN
        |-> carrier_high_signal == (carrier_high_signal_pin_s ^ carrier_high_invert))
        else $error("carrier-high polarity wrong");

    carrier_low_signal_invert_a: assert property (
        carrier_low_field == `SM_CAR_PIN
        |-> carrier_low_signal == (carrier_low_signal_pin_s ^ carrier_low_invert))
        else $error("carrier-low polarity wrong");

    // Mixing and carrier hand-over
    mix_select_a: assert property (
        enable_bit && !output_invert && !hold_high && !hold_low && !module_power_disable
        |=> modulated_output == $past(plain_mix)) else $error("wrong carrier mixed");

    reenable_mix_a: assert property (
        $rose(enable_bit) && !output_invert && !hold_high && !hold_low && !module_power_disable
        |=> modulated_output == $past(plain_mix)) else $error("mixing not resumed");

    low_sync_hold_a: assert property (
        car_q == sm_pkg::SM_USE_LOW && hold_low |-> car_d == sm_pkg::SM_USE_LOW)
        else $error("left low carrier before fall");

    high_release_a: assert property (
        car_q == sm_pkg::SM_USE_HIGH && !want_high && carrier_high_signal_fall
        |-> car_d == sm_pkg::SM_USE_LOW) else $error("high carrier not released");

    low_release_a: assert property (
        car_q == sm_pkg::SM_USE_LOW && want_high && carrier_low_signal_fall
        |-> car_d == sm_pkg::SM_USE_HIGH) else $error("low carrier not released");

    // Reset, power-down and register port
    reset_defaults_a: assert property (
        @(posedge core_clk) disable iff (!clk_en)
        !reset_n |=> control_q == `SM_RST_BYTE && carrier_options_q == `SM_RST_BYTE &&
                     !modulated_output) else $error("reset defaults missing");

    power_out_a: assert property (
        module_power_disable |=> !modulated_output && carrier_options_q == 8'h00)
        else $error("output alive while powered down");

    ctl_write_a: assert property (
        reg_wr && hit_ctl && !module_power_disable
        |=> control_q == ($past(reg_wdata) & 8'h91)) else $error("control write lost");

    opt_write_a: assert property (
        reg_wr && hit_opt && !module_power_disable
        |=> carrier_options_q == ($past(reg_wdata) & 8'h33)) else $error("options write lost");

    src_write_a: assert property (
        reg_wr && hit_src && !module_power_disable
        |=> mod_src_q == ($past(reg_wdata) & 8'h3F)) else $error("source write lost");

    carrier_high_signal_write_a: assert property (
        reg_wr && hit_carrier_high_signal && !module_power_disable
        |=> carrier_high_signal_sel_q == ($past(reg_wdata) & 8'h1F)) else $error("carrier-high write lost");

    carrier_low_signal_write_a: assert property (
        reg_wr && hit_carrier_low_signal && !module_power_disable
        |=> carrier_low_signal_sel_q == ($past(reg_wdata) & 8'h1F)) else $error("carrier-low write lost");

    unmapped_write_a: assert property (
        reg_wr && !hit_ctl && !hit_opt && !hit_src && !hit_carrier_low_signal && !hit_carrier_high_signal && !module_power_disable
        |=> $stable(control_q) && $stable(mod_src_q) && $stable(carrier_high_signal_sel_q))
        else $error("unmapped write landed");

    read_idle_a: assert property (
        !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read slot");
endmodule : sm_modulator
`default_nettype wire

// ===== verilog/sm_regs.svh
`ifndef SM_REGS_SVH
`define SM_REGS_SVH
// Register offsets (byte addresses on the register port)
`define SM_ADDR_W          8
`define SM_OFF_CONTROL     8'h6A
`define SM_OFF_CARRIER_OPT 8'h6B
`define SM_OFF_MOD_SRC     8'h6C
`define SM_OFF_CARRIER_LOW_SIGNAL_SEL    8'h6D
`define SM_OFF_CARRIER_HIGH_SIGNAL_SEL    8'h6E
// Control register fields
`define SM_CTL_EN          7
`define SM_CTL_OUT         5
`define SM_CTL_OUTPUT_INVERT        4
`define SM_CTL_BIT         0
// Carrier options fields
`define SM_OPT_CARRIER_HIGH_INVERT       5
`define SM_OPT_CARRIER_HIGH_SYNC_ENABLE      4
`define SM_OPT_CARRIER_LOW_INVERT       1
`define SM_OPT_CARRIER_LOW_SYNC_ENABLE      0
// Select codes
`define SM_MS_PIN          6'h00
`define SM_MS_SWBIT        6'h01
`define SM_MS_LAST         6'h20
`define SM_CAR_PIN         5'h00
`define SM_CAR_SYSCLK      5'h01
`define SM_CAR_LAST        5'h16
`define SM_CAR_RSVD        5'h0B
`define SM_MS_RSVD_A       6'h0B
`define SM_MS_RSVD_B       6'h0C
// Reset values
`define SM_RST_BYTE        8'h00
`endif

// ===== verilog/sm_pkg.sv
package sm_pkg;
    typedef logic [5:0] sm_msel_t;
    typedef logic [4:0] sm_csel_t;
    // Which carrier feeds the mixer
    typedef enum logic [0:0] {
        SM_USE_LOW  = 1'b0,
        SM_USE_HIGH = 1'b1
    } sm_car_e;
endpackage : sm_pkg

// ===== verilog/sm_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser bank for asynchronous inputs
module sm_sync2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk, // Clock
    input  wire logic             clk_en,   // Clock enable
    input  wire logic [WIDTH-1:0] async_in, // Asynchronous inputs
    output var  logic [WIDTH-1:0] sync_out  // Synchronised outputs
);
    logic [WIDTH-1:0] meta_q;

    // First stage only feeds the second
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sm_sync2
`default_nettype wire

// ===== tb/sm_sources.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side sources: the selected code carries the level, all other codes its inverse
module sm_sources (
    input  wire logic [4:0]  ch_code,  // Code carrying the high carrier
    input  wire logic        ch_lvl,   // High carrier level
    input  wire logic [4:0]  cl_code,  // Code carrying the low carrier
    input  wire logic        cl_lvl,   // Low carrier level
    input  wire logic [5:0]  ms_code,  // Code carrying the modulator
    input  wire logic        ms_lvl,   // Modulator level
    output var  logic        mod_pin,  // Modulator pin
    output var  logic        carrier_high_signal_pin, // High carrier pin
    output var  logic        carrier_low_signal_pin, // Low carrier pin
    output var  logic [32:0] mod_vec,  // Modulator peripherals
    output var  logic [22:0] carrier_high_signal_vec, // High carrier peripherals
    output var  logic [22:0] carrier_low_signal_vec  // Low carrier peripherals
);
    // Sources keep running whatever the core does; unselected lines never copy the level
    always_comb begin
        mod_pin  = (ms_code == 6'h00) ? ms_lvl : ~ms_lvl;
        carrier_high_signal_pin = (ch_code == 5'h00) ? ch_lvl : ~ch_lvl;
        carrier_low_signal_pin = (cl_code == 5'h00) ? cl_lvl : ~cl_lvl;
        for (int i = 0; i < 33; i++) begin
            mod_vec[i] = (ms_code == 6'(i)) ? ms_lvl : ~ms_lvl;
        end
        for (int i = 0; i < 23; i++) begin
            carrier_high_signal_vec[i] = (ch_code == 5'(i)) ? ch_lvl : ~ch_lvl;
            carrier_low_signal_vec[i] = (cl_code == 5'(i)) ? cl_lvl : ~cl_lvl;
        end
    end
endmodule : sm_sources
`default_nettype wire

// ===== tb/sm_modulator_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sm_regs.svh"
module sm_modulator_bench;
    logic core_clk, reset_n, pwr_dis, wr, rd, mout, mpin, hpin, lpin, hl, ll, ml, chi;
    logic [7:0] addr, wdata, rdata;
    logic [4:0] ch_code, cl_code;
    logic [5:0] ms_code;
    logic [32:0] mvec;
    logic [22:0] hvec, lvec;
    int mismatches, n_compared, cycles;
    logic [5:0] mc [7] = '{6'h00, 6'h01, 6'h02, 6'h20, 6'h0B, 6'h0C, 6'h21};
    logic       mx [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [4:0] cc [6] = '{5'h00, 5'h02, 5'h16, 5'h0B, 5'h17, 5'h1F};
    logic       cx [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    sm_modulator sm_modulator_inst (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
        .module_power_disable(pwr_dis), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .modulator_pin_route(mpin),
        .carrier_high_pin_route(hpin), .carrier_low_pin_route(lpin), .mod_periph_in(mvec),
        .carrier_high_signal_periph_in(hvec), .carrier_low_signal_periph_in(lvec), .modulated_output(mout),
        .carrier_active_high(chi));
    sm_sources sm_sources_inst (.ch_code(ch_code), .ch_lvl(hl), .cl_code(cl_code),
        .cl_lvl(ll), .ms_code(ms_code), .ms_lvl(ml), .mod_pin(mpin), .carrier_high_signal_pin(hpin),
        .carrier_low_signal_pin(lpin), .mod_vec(mvec), .carrier_high_signal_vec(hvec), .carrier_low_signal_vec(lvec));

    // Clock at 20 MHz
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        if (mismatches == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp1

    task automatic wrb(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wrb

    // Read data stand only in the cycle after the strobe
    task automatic rdb(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 cmp8(rdata, exp);
    endtask : rdb

    task automatic settle(input logic exp);
        repeat (4) @(posedge core_clk);
        #1 cmp1(mout, exp);
    endtask : settle

    task automatic lv(input logic h, input logic l, input logic m);
        @(posedge core_clk);
        hl <= h;
        ll <= l;
        ml <= m;
    endtask : lv

    task automatic run(input logic [4:0] ch, input logic [4:0] cl, input logic [5:0] ms,
                       input logic [7:0] opt, input logic [7:0] ctl, input logic exp);
        @(posedge core_clk);
        ch_code <= ch;
        cl_code <= cl;
        ms_code <= ms;
        wrb(`SM_OFF_CARRIER_HIGH_SIGNAL_SEL, {3'h0, ch});
        wrb(`SM_OFF_CARRIER_LOW_SIGNAL_SEL, {3'h0, cl});
        wrb(`SM_OFF_MOD_SRC, {2'h0, ms});
        wrb(`SM_OFF_CARRIER_OPT, opt);
        wrb(`SM_OFF_CONTROL, ctl);
        settle(exp);
    endtask : run

    task automatic check_reset();
        for (int i = 0; i < 5; i++) rdb(`SM_OFF_CONTROL + 8'(i), 8'h00);
    endtask : check_reset

    task automatic check_masks();
        wrb(`SM_OFF_CARRIER_OPT, 8'hFF);
        rdb(`SM_OFF_CARRIER_OPT, 8'h33);
        wrb(`SM_OFF_MOD_SRC, 8'hFF);
        rdb(`SM_OFF_MOD_SRC, 8'h3F);
        wrb(`SM_OFF_CARRIER_LOW_SIGNAL_SEL, 8'hFF);
        rdb(`SM_OFF_CARRIER_LOW_SIGNAL_SEL, 8'h1F);
        wrb(`SM_OFF_CARRIER_HIGH_SIGNAL_SEL, 8'hFF);
        rdb(`SM_OFF_CARRIER_HIGH_SIGNAL_SEL, 8'h1F);
        wrb(8'h69, 8'hFF);
        rdb(8'h69, 8'h00);
    endtask : check_masks

    // Every source code family but the carrier system clock, valid and reserved
    task automatic check_select();
        lv(1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 7; i++) run(5'h00, 5'h00, mc[i], 8'h00, 8'h81, mx[i]);
        for (int i = 0; i < 6; i++) run(cc[i], 5'h00, 6'h01, 8'h00, 8'h81, cx[i]);
        lv(1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 6; i++) run(5'h00, cc[i], 6'h01, 8'h00, 8'h80, cx[i]);
        lv(1'b1, 1'b0, 1'b0);
        run(5'h00, 5'h00, 6'h02, 8'h00, 8'h81, 1'b0);
    endtask : check_select

    task automatic check_polarity();
        lv(1'b0, 1'b0, 1'b0);
        run(5'h00, 5'h00, 6'h01, 8'h20, 8'h81, 1'b1);
        run(5'h00, 5'h00, 6'h01, 8'h02, 8'h80, 1'b1);
        run(5'h00, 5'h00, 6'h01, 8'h00, 8'h10, 1'b1);
        rdb(`SM_OFF_CONTROL, 8'h30);
        run(5'h00, 5'h00, 6'h01, 8'h22, 8'h91, 1'b0);
    endtask : check_polarity

    task automatic check_sync();
        lv(1'b1, 1'b0, 1'b0);
        run(5'h00, 5'h00, 6'h01, 8'h00, 8'h81, 1'b1);
        wrb(`SM_OFF_CONTROL, 8'h80);
        settle(1'b0);
        run(5'h00, 5'h00, 6'h01, 8'h10, 8'h81, 1'b1);
        wrb(`SM_OFF_CONTROL, 8'h80);
        settle(1'b1);
        cmp1(chi, 1'b1);
        lv(1'b0, 1'b0, 1'b0);
        settle(1'b0);
        cmp1(chi, 1'b0);
        lv(1'b0, 1'b1, 1'b0);
        run(5'h00, 5'h00, 6'h01, 8'h01, 8'h80, 1'b1);
        wrb(`SM_OFF_CONTROL, 8'h81);
        settle(1'b1);
        lv(1'b0, 1'b0, 1'b0);
        settle(1'b0);
    endtask : check_sync

    task automatic check_disable();
        lv(1'b1, 1'b0, 1'b0);
        run(5'h02, 5'h00, 6'h01, 8'h00, 8'h81, 1'b1);
        wrb(`SM_OFF_CONTROL, 8'h01);
        settle(1'b0);
        rdb(`SM_OFF_CARRIER_HIGH_SIGNAL_SEL, 8'h02);
        rdb(`SM_OFF_MOD_SRC, 8'h01);
        wrb(`SM_OFF_CONTROL, 8'h81);
        settle(1'b1);
    endtask : check_disable

    task automatic check_power();
        @(posedge core_clk);
        pwr_dis <= 1'b1;
        wrb(`SM_OFF_MOD_SRC, 8'h05);
        settle(1'b0);
        @(posedge core_clk);
        pwr_dis <= 1'b0;
        check_reset();
    endtask : check_power

    task automatic check_midreset();
        run(5'h02, 5'h03, 6'h01, 8'h33, 8'h91, 1'b0);
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        check_reset();
        settle(1'b0);
    endtask : check_midreset

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        {reset_n, pwr_dis, wr, rd, hl, ll, ml} = 7'h00;
        {addr, wdata, ch_code, cl_code, ms_code} = 32'h0000_0000;
        {mismatches, n_compared, cycles} = 96'h0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        check_reset();
        check_masks();
        check_select();
        check_polarity();
        check_sync();
        check_disable();
        check_power();
        check_midreset();
        report_and_stop();
    end
endmodule : sm_modulator_bench
`default_nettype wire
